// >>> design/dmac_engine.sv
// How it works
// - 17x17 multiplier and scaler give 1.31 fraction or 32-bit integer.
// - unsigned operands zero-extend into bit 16, signed ones sign-extend.
// - scaler output is 33 bits, sign-extended to 40 before the adder.
// - fractional mode treats operands as 1.15, yielding a 1.31 product.
// - same multiplier does signed, unsigned and mixed integer multiplies.
// - general multiply gives 16-bit result for bytes, 32-bit for words.
// - 40-bit adder picks one accumulator as source and destination.
// - load and add of data words may pass through the barrel shifter.
// - adder has zero-forced input; subtract complements with borrow low.
// - per-accumulator overflow and saturation flags latch into status.
// - guard overflow flag set when bits 39..32 differ.
// - signed overflow of bit 39 (sum bits 40 and 39 differ) counts as catastrophic overflow.
// - saturation uses result, flags, per-acc enables and mode select.
// - dsp multiply and saturation settings come from config bits; general multiply takes its sign bits from the command.
// - accumulator-to-accumulator add, subtract and negate need no data.
// - clear, square difference, multiply load/add/sub/negate, prefetch.
// - saturated flag means bit 31 or bit 39 overflow by mode when enabled; with saturation off it means bit 39 overflow.
// - bit 39 mode saturates to 0x7fffffffff or 0x8000000000.
// - bit 31 mode saturates to 0x007fffffff or 0x0080000000; guard flags stay clear.
// - saturated flags are sticky; only software clears them.
// - status holds OR of guard flags and OR of saturated flags.
`timescale 1ns/10ps
`default_nettype none

module dmac_engine
  import dmac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [15:0] core_config_reg;
  logic [15:0] cmd;
  logic [31:0] operand;
  logic [31:0] mul_result;
  logic [39:0] acc [2];
  logic [1:0] guard_ovf;
  logic [1:0] saturated;
  logic exec_go;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic wr_fire;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;

  assign s_axi_awready = ~aw_full;
  assign s_axi_wready = ~w_full;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_full <= 1'b0;
      if (s_axi_wvalid && !w_full)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_full <= 1'b0;
    end
  end

  always_comb
  begin
    case (aw_addr & 8'hfc)
      DMAC_OFS_CONFIG, DMAC_OFS_STATUS, DMAC_OFS_CMD,
      DMAC_OFS_OPERAND: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= DMAC_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? DMAC_RESP_OKAY : DMAC_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // byte lanes merge into the stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        m[8*b +: 8] = nw[8*b +: 8];
    return m;
  endfunction : merge

  logic cfg_wr;
  logic cmd_wr;
  logic opnd_wr;
  logic [1:0] sat_clr;
  logic [31:0] cfg_m;
  logic [31:0] cmd_m;

  assign cfg_wr = wr_fire && (aw_addr & 8'hfc) == DMAC_OFS_CONFIG;
  assign cmd_wr = wr_fire && (aw_addr & 8'hfc) == DMAC_OFS_CMD;
  assign opnd_wr = wr_fire && (aw_addr & 8'hfc) == DMAC_OFS_OPERAND;
  assign cfg_m = merge({16'h0000, core_config_reg}, w_data, w_strb);
  assign cmd_m = merge({16'h0000, cmd}, w_data, w_strb);
  // write one to clear the sticky saturated bits
  assign sat_clr = (wr_fire && (aw_addr & 8'hfc) == DMAC_OFS_STATUS
                    && w_strb[0]) ? w_data[DMAC_ST_SAT +: 2] : 2'b00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      core_config_reg <= DMAC_CFG_RESET;
      cmd <= 16'h0000;
      operand <= 32'h00000000;
      exec_go <= 1'b0;
    end
    else
    begin
      if (cfg_wr)
        core_config_reg <= cfg_m[15:0] & DMAC_CFG_WMASK;
      if (cmd_wr)
        cmd <= cmd_m[15:0];
      if (opnd_wr)
        operand <= merge(operand, w_data, w_strb);
      exec_go <= cmd_wr;
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr & 8'hfc)
      DMAC_OFS_CONFIG: rd_mux = {16'h0000, core_config_reg};
      DMAC_OFS_STATUS: rd_mux = {26'h0000000, |saturated, |guard_ovf,
                                 saturated, guard_ovf};
      DMAC_OFS_CMD: rd_mux = {16'h0000, cmd};
      DMAC_OFS_OPERAND: rd_mux = operand;
      DMAC_OFS_ACC1_LO: rd_mux = acc[0][31:0];
      DMAC_OFS_ACC1_HI: rd_mux = {24'h000000, acc[0][39:32]};
      DMAC_OFS_ACC2_LO: rd_mux = acc[1][31:0];
      DMAC_OFS_ACC2_HI: rd_mux = {24'h000000, acc[1][39:32]};
      DMAC_OFS_MUL: rd_mux = mul_result;
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= DMAC_RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? DMAC_RESP_OKAY : DMAC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // multiplier operand preparation
  dmac_op_t op;
  logic tgt;
  logic [16:0] mx;
  logic [16:0] my;
  logic [16:0] diff;
  logic mfrac;
  logic [32:0] prod;
  logic [39:0] prod40;
  logic xuns;
  logic yuns;

  assign op = dmac_op_t'(cmd[DMAC_CMD_OP_LSB +: 4]);
  assign tgt = cmd[DMAC_CMD_ACC];
  // general multiply picks sign per operand; dsp ops use the config bit
  assign xuns = (op == general_multiply_op) ? cmd[DMAC_CMD_XUNS]
                : core_config_reg[DMAC_CFG_UNSIGNED];
  assign yuns = (op == general_multiply_op) ? cmd[DMAC_CMD_YUNS]
                : core_config_reg[DMAC_CFG_UNSIGNED];
  assign diff = {operand[15], operand[15:0]} - {operand[31], operand[31:16]};

  always_comb
  begin
    mfrac = core_config_reg[DMAC_CFG_FRAC] && op != general_multiply_op;
    if (op == sq_diff_load_op || op == sq_diff_accumulate_op)
    begin
      mx = diff;
      my = diff;
    end
    else if (op == general_multiply_op && cmd[DMAC_CMD_BYTE])
    begin
      mx = {{9{operand[7] & ~xuns}}, operand[7:0]};
      my = {{9{operand[23] & ~yuns}}, operand[23:16]};
    end
    else
    begin
      mx = {operand[15] & ~xuns, operand[15:0]};
      my = {operand[31] & ~yuns, operand[31:16]};
    end
  end

  dmac_mul_scaler u_mul (
    .op_x(mx),
    .op_y(my),
    .frac(mfrac),
    .product(prod)
  );

  assign prod40 = {{7{prod[32]}}, prod};

  ////////////////////////////////////////////////////////////////////////
  // barrel shift of a data word, positive amount shifts right
  logic [39:0] data40;
  logic [39:0] shifted;
  logic [4:0] sh;

  assign data40 = {{8{operand[15]}}, operand[15:0], 16'h0000};
  assign sh = cmd[DMAC_CMD_SH_LSB +: 5];

  always_comb
  begin
    if (!sh[4])
      shifted = 40'($signed(data40) >>> sh[3:0]);
    else
      shifted = data40 << 5'(-sh);
  end

  ////////////////////////////////////////////////////////////////////////
  // 40-bit adder/subtractor
  logic [39:0] add_a;
  logic [39:0] add_b;
  logic add_sub;
  logic add_zero;
  logic [39:0] addend;
  logic [40:0] sum;
  logic [39:0] res;
  logic ov39;
  logic guard_cond;
  logic ov31;
  logic passes;

  always_comb
  begin
    add_zero = 1'b0;
    add_sub = 1'b0;
    add_b = prod40;
    passes = 1'b1;
    case (op)
      acc_clear_op:
      begin
        add_zero = 1'b1;
        add_b = 40'h0000000000;
      end
      sq_diff_load_op, multiply_load_op: add_zero = 1'b1;
      sq_diff_accumulate_op, multiply_accumulate_op: add_zero = 1'b0;
      negated_multiply_load_op:
      begin
        add_zero = 1'b1;
        add_sub = 1'b1;
      end
      multiply_subtract_op: add_sub = 1'b1;
      acc_load_op:
      begin
        add_zero = 1'b1;
        add_b = shifted;
      end
      acc_add_data_op: add_b = shifted;
      acc_add_acc_op: add_b = acc[~tgt];
      acc_sub_acc_op:
      begin
        add_b = acc[~tgt];
        add_sub = 1'b1;
      end
      acc_negate_op:
      begin
        add_zero = 1'b1;
        add_b = acc[tgt];
        add_sub = 1'b1;
      end
      default: passes = 1'b0;
    endcase
  end

  assign add_a = add_zero ? 40'h0000000000 : acc[tgt];
  // subtract: complemented input, borrow-in inactive means carry of one
  assign addend = add_sub ? ~add_b : add_b;
  assign sum = {add_a[39], add_a} + {addend[39], addend}
               + {40'h0000000000, add_sub};
  assign res = sum[39:0];
  assign ov39 = sum[40] ^ sum[39];
  assign guard_cond = ~(&res[39:31] | ~|res[39:31])
                      ? ~(&res[39:32] | ~|res[39:32]) : 1'b0;
  assign ov31 = ov39 | ~(&res[39:31] | ~|res[39:31]);

  ////////////////////////////////////////////////////////////////////////
  // general multiply result: low half for bytes, full word otherwise
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mul_result <= 32'h00000000;
    else if (exec_go && op == general_multiply_op)
      mul_result <= cmd[DMAC_CMD_BYTE] ? {16'h0000, prod[15:0]}
                    : prod[31:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // per-accumulator saturation, write back and flags
  logic mode31;
  logic [1:0] sat_en;
  logic [39:0] sat_val;
  logic sat_hit;

  assign mode31 = core_config_reg[DMAC_CFG_SATMODE];
  assign sat_en = {core_config_reg[DMAC_CFG_SAT_B],
                   core_config_reg[DMAC_CFG_SAT_A]};
  // true sign comes from the 41-bit sum, valid even after bit 39 overflow
  assign sat_hit = mode31 ? ov31 : ov39;
  assign sat_val = mode31 ? (sum[40] ? DMAC_SAT31_NEG : DMAC_SAT31_POS)
                   : (sum[40] ? DMAC_SAT39_NEG : DMAC_SAT39_POS);

  for (genvar i = 0; i < 2; i++)
  begin : g_acc
    logic hit;
    logic set_sat;
    assign hit = exec_go && passes && tgt == 1'(i);
    // saturation off still flags a catastrophic bit 39 overflow
    assign set_sat = hit && (sat_en[i] ? sat_hit : ov39);

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        acc[i] <= 40'h0000000000;
        guard_ovf[i] <= 1'b0;
      end
      else
      begin
        if (hit && sat_en[i] && sat_hit)
          acc[i] <= sat_val;
        else if (hit)
          acc[i] <= res;
        // flags follow the stored value; bit 31 mode keeps them clear
        if (hit || mode31)
          guard_ovf[i] <= !mode31 && (guard_cond || (sat_en[i] && sat_hit));
      end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        saturated[i] <= 1'b0;
      else
        saturated[i] <= (saturated[i] & ~sat_clr[i]) | set_sat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_exec_a(dmac_op_t o);
    exec_go && tgt == 1'b0 && op == o;
  endsequence

  a_sat_sticky: assert property (
    saturated[0] && !sat_clr[0] |=> saturated[0])
    else $error("saturated flag dropped without clear");
  a_guard_mode31: assert property (
    exec_go && mode31 |=> guard_ovf == 2'b00)
    else $error("guard flag set in bit 31 mode");
  a_sat39_limit: assert property (
    exec_go && passes && !tgt && sat_en[0] && !mode31 && ov39
    |=> (acc[0] == DMAC_SAT39_POS || acc[0] == DMAC_SAT39_NEG)
    && saturated[0])
    else $error("bit 39 saturation value wrong");
  a_sat31_limit: assert property (
    exec_go && passes && !tgt && sat_en[0] && mode31 && ov31
    |=> (acc[0] == DMAC_SAT31_POS || acc[0] == DMAC_SAT31_NEG)
    && saturated[0])
    else $error("bit 31 saturation value wrong");
  a_no_sat_raw: assert property (
    exec_go && passes && !tgt && !sat_en[0]
    |=> acc[0] == $past(res) && saturated[0] == ($past(ov39)
    || $past(saturated[0]) && !$past(sat_clr[0])))
    else $error("unsaturated write wrong");
  a_clear_zero: assert property (
    s_exec_a(acc_clear_op) |=> acc[0] == '0)
    else $error("clear did not zero accumulator");
  a_prefetch_keep: assert property (
    s_exec_a(prefetch_only_op) |=> $stable(acc[0]) && $stable(guard_ovf))
    else $error("prefetch changed accumulator");
  a_mul_word: assert property (
    exec_go && op == general_multiply_op && !cmd[DMAC_CMD_BYTE]
    |=> mul_result == $past(prod[31:0]))
    else $error("word multiply result wrong");
  a_guard_bits: assert property (
    exec_go && passes && !tgt && !mode31
    |=> guard_ovf[0] == (acc[0][39:32] != {8{acc[0][39]}}))
    else $error("guard flag disagrees with accumulator");

endmodule : dmac_engine
`default_nettype wire

// >>> shared/dmac_pkg.sv
package dmac_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] DMAC_OFS_CONFIG = 8'h00;
  localparam logic [7:0] DMAC_OFS_STATUS = 8'h04;
  localparam logic [7:0] DMAC_OFS_CMD = 8'h08;
  localparam logic [7:0] DMAC_OFS_OPERAND = 8'h0c;
  localparam logic [7:0] DMAC_OFS_ACC1_LO = 8'h10;
  localparam logic [7:0] DMAC_OFS_ACC1_HI = 8'h14;
  localparam logic [7:0] DMAC_OFS_ACC2_LO = 8'h18;
  localparam logic [7:0] DMAC_OFS_ACC2_HI = 8'h1c;
  localparam logic [7:0] DMAC_OFS_MUL = 8'h20;

  // core_config_reg field positions
  localparam int DMAC_CFG_FRAC = 0;
  localparam int DMAC_CFG_ROUND = 1;
  localparam int DMAC_CFG_SATMODE = 4;
  localparam int DMAC_CFG_DWSAT = 5;
  localparam int DMAC_CFG_SAT_B = 6;
  localparam int DMAC_CFG_SAT_A = 7;
  localparam int DMAC_CFG_UNSIGNED = 12;
  localparam logic [15:0] DMAC_CFG_WMASK = 16'h10f3;
  localparam logic [15:0] DMAC_CFG_RESET = 16'h0001;

  // status register field positions
  localparam int DMAC_ST_GUARD = 0;
  localparam int DMAC_ST_SAT = 2;
  localparam int DMAC_ST_ANY_GUARD = 4;
  localparam int DMAC_ST_ANY_SAT = 5;

  // command register field positions
  localparam int DMAC_CMD_OP_LSB = 0;
  localparam int DMAC_CMD_ACC = 4;
  localparam int DMAC_CMD_SH_LSB = 5;
  localparam int DMAC_CMD_BYTE = 10;
  localparam int DMAC_CMD_XUNS = 11;
  localparam int DMAC_CMD_YUNS = 12;

  // saturation targets
  localparam logic [39:0] DMAC_SAT39_POS = 40'h7fffffffff;
  localparam logic [39:0] DMAC_SAT39_NEG = 40'h8000000000;
  localparam logic [39:0] DMAC_SAT31_POS = 40'h007fffffff;
  localparam logic [39:0] DMAC_SAT31_NEG = 40'h0080000000;

  localparam logic [1:0] DMAC_RESP_OKAY = 2'b00;
  localparam logic [1:0] DMAC_RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    acc_clear_op,
    sq_diff_load_op,
    sq_diff_accumulate_op,
    multiply_accumulate_op,
    prefetch_only_op,
    multiply_load_op,
    negated_multiply_load_op,
    multiply_subtract_op,
    acc_load_op,
    acc_add_data_op,
    acc_add_acc_op,
    acc_sub_acc_op,
    acc_negate_op,
    general_multiply_op
  } dmac_op_t;

endpackage : dmac_pkg

// >>> design/dmac_mul_scaler.sv
`timescale 1ns/10ps
`default_nettype none

module dmac_mul_scaler
  import dmac_pkg::*;
(
  input wire logic [16:0] op_x,
  input wire logic [16:0] op_y,
  input wire logic frac,
  output logic [32:0] product
);

  logic signed [33:0] raw;

  // operands arrive already widened to 17 bits, so one signed multiply
  // covers signed, unsigned and mixed forms
  assign raw = $signed(op_x) * $signed(op_y);

  // fractional scaling drops the duplicated sign bit: 1.15 x 1.15 -> 1.31
  always_comb
  begin
    if (frac)
      product = {raw[31:0], 1'b0};
    else
      product = raw[32:0];
  end

endmodule : dmac_mul_scaler
`default_nettype wire

// >>> bench/dmac_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none

module dmac_cpu_model
  import dmac_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic req_write,
  input wire logic slow,
  input wire logic [7:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic done,
  output logic [31:0] rsp_data,
  output logic [1:0] rsp_resp,
  output logic [7:0] m_awaddr,
  output logic m_awvalid,
  input wire logic m_awready,
  output logic [31:0] m_wdata,
  output logic [3:0] m_wstrb,
  output logic m_wvalid,
  input wire logic m_wready,
  input wire logic [1:0] m_bresp,
  input wire logic m_bvalid,
  output logic m_bready,
  output logic [7:0] m_araddr,
  output logic m_arvalid,
  input wire logic m_arready,
  input wire logic [31:0] m_rdata,
  input wire logic [1:0] m_rresp,
  input wire logic m_rvalid,
  output logic m_rready
);

  logic busy;

  //////////////////////////////////////////////////////////////////////////
  // released lines flip to the inverse so a late sampler never sees a match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rsp_data <= 32'h00000000;
      rsp_resp <= 2'h0;
      m_awaddr <= 8'h00;
      m_awvalid <= 1'b0;
      m_wdata <= 32'h00000000;
      m_wstrb <= 4'hf;
      m_wvalid <= 1'b0;
      m_bready <= 1'b0;
      m_araddr <= 8'h00;
      m_arvalid <= 1'b0;
      m_rready <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (req && !busy)
      begin
        busy <= 1'b1;
        m_awaddr <= req_addr;
        m_araddr <= req_addr;
        m_wdata <= req_wdata;
        m_awvalid <= req_write;
        m_wvalid <= req_write;
        m_arvalid <= !req_write;
        // a slow master raises ready only after the answer is offered
        m_bready <= req_write && !slow;
        m_rready <= !req_write && !slow;
      end
      if (m_awvalid && m_awready)
      begin
        m_awvalid <= 1'b0;
        m_awaddr <= ~m_awaddr;
      end
      if (m_wvalid && m_wready)
      begin
        m_wvalid <= 1'b0;
        m_wdata <= ~m_wdata;
      end
      if (m_arvalid && m_arready)
      begin
        m_arvalid <= 1'b0;
        m_araddr <= ~m_araddr;
      end
      if (busy && m_bvalid && !m_bready)
        m_bready <= 1'b1;
      if (busy && m_rvalid && !m_rready)
        m_rready <= 1'b1;
      if (m_bready && m_bvalid)
      begin
        m_bready <= 1'b0;
        rsp_resp <= m_bresp;
        done <= 1'b1;
        busy <= 1'b0;
      end
      if (m_rready && m_rvalid)
      begin
        m_rready <= 1'b0;
        rsp_resp <= m_rresp;
        rsp_data <= m_rdata;
        done <= 1'b1;
        busy <= 1'b0;
      end
    end
  end

endmodule : dmac_cpu_model

`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("BAD %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_top
  import dmac_pkg::*;
;

  typedef struct packed {
    logic [15:0] cfg;
    logic [31:0] opnd;
    logic [15:0] cmd;
    logic [39:0] acc;
    logic [7:0] st;
    logic clr;
  } dmac_row_t;

  // rows run in order: accumulator and sticky flags carry from row to row
  dmac_row_t rows [29] = '{
    '{16'h0001, 32'h40004000, 16'h0005, 40'h0020000000, 8'h00, 1'b0},
    '{16'h0001, 32'h40004000, 16'h0003, 40'h0040000000, 8'h00, 1'b0},
    '{16'h0000, 32'h0002ffff, 16'h0005, 40'hfffffffffe, 8'h00, 1'b0},
    '{16'h0000, 32'h0002ffff, 16'h0006, 40'h0000000002, 8'h00, 1'b0},
    '{16'h0000, 32'h00040003, 16'h0007, 40'hfffffffff6, 8'h00, 1'b0},
    '{16'h0000, 32'h00020005, 16'h0001, 40'h0000000009, 8'h00, 1'b0},
    '{16'h0000, 32'h00020005, 16'h0002, 40'h0000000012, 8'h00, 1'b0},
    '{16'h0000, 32'h00020005, 16'h0004, 40'h0000000012, 8'h00, 1'b0},
    '{16'h0000, 32'h00020005, 16'h0000, 40'h0000000000, 8'h00, 1'b0},
    '{16'h1000, 32'hffffffff, 16'h0005, 40'h00fffe0001, 8'h00, 1'b0},
    '{16'h1000, 32'hffffffff, 16'h0003, 40'h01fffc0002, 8'h11, 1'b0},
    '{16'h1000, 32'hffffffff, 16'h0007, 40'h00fffe0001, 8'h00, 1'b0},
    '{16'h0080, 32'h00007fff, 16'h0308, 40'h7fff000000, 8'h11, 1'b0},
    '{16'h0080, 32'h00007fff, 16'h0309, 40'h7fffffffff, 8'h35, 1'b0},
    '{16'h0080, 32'h00000001, 16'h0028, 40'h0000008000, 8'h24, 1'b1},
    '{16'h0090, 32'h00007fff, 16'h0008, 40'h007fff0000, 8'h00, 1'b0},
    '{16'h0090, 32'h00007fff, 16'h0009, 40'h007fffffff, 8'h24, 1'b1},
    '{16'h0090, 32'h00008000, 16'h0008, 40'hff80000000, 8'h00, 1'b0},
    '{16'h0090, 32'h00008000, 16'h0009, 40'h0080000000, 8'h24, 1'b1},
    '{16'h0000, 32'h00000001, 16'h0018, 40'h0000010000, 8'h00, 1'b0},
    '{16'h0000, 32'h00000000, 16'h001a, 40'h0080010000, 8'h00, 1'b0},
    '{16'h0000, 32'h00000000, 16'h001b, 40'h0000010000, 8'h00, 1'b0},
    '{16'h0000, 32'h00000000, 16'h001c, 40'hffffff0000, 8'h00, 1'b0},
    '{16'h0000, 32'h00008000, 16'h0308, 40'h8000000000, 8'h11, 1'b0},
    '{16'h0000, 32'h00008000, 16'h0309, 40'h0000000000, 8'h24, 1'b1},
    '{16'h0000, 32'h0003fffe, 16'h000d, 40'h00fffffffa, 8'h00, 1'b0},
    '{16'h0000, 32'h0003fffe, 16'h080d, 40'h000002fffa, 8'h00, 1'b0},
    '{16'h0000, 32'h000300fe, 16'h040d, 40'h000000fffa, 8'h00, 1'b0},
    '{16'h0000, 32'hffffffff, 16'h180d, 40'h00fffe0001, 8'h00, 1'b0}
  };

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic slow = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [31:0] req_wdata = 32'h00000000;
  logic done;
  logic [31:0] rsp_data;
  logic [1:0] rsp_resp;
  logic [7:0] s_axi_awaddr;
  logic [7:0] s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp;
  logic [1:0] s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int bad_count = 0;
  int tests_run = 0;

  always #50 aclk = ~aclk;

  //////////////////////////////////////////////////////////////////////////
  dmac_engine dmac_engine_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  dmac_cpu_model dmac_cpu_model_inst (
    .aclk(aclk), .aresetn(aresetn), .req(req), .req_write(req_write),
    .slow(slow), .req_addr(req_addr), .req_wdata(req_wdata), .done(done),
    .rsp_data(rsp_data), .rsp_resp(rsp_resp),
    .m_awaddr(s_axi_awaddr), .m_awvalid(s_axi_awvalid),
    .m_awready(s_axi_awready), .m_wdata(s_axi_wdata),
    .m_wstrb(s_axi_wstrb), .m_wvalid(s_axi_wvalid),
    .m_wready(s_axi_wready), .m_bresp(s_axi_bresp),
    .m_bvalid(s_axi_bvalid), .m_bready(s_axi_bready),
    .m_araddr(s_axi_araddr), .m_arvalid(s_axi_arvalid),
    .m_arready(s_axi_arready), .m_rdata(s_axi_rdata),
    .m_rresp(s_axi_rresp), .m_rvalid(s_axi_rvalid),
    .m_rready(s_axi_rready));

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // entered just after a rising edge; the model pulses done on the answer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [1:0] r);
    int n;
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge aclk);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= 60)
    begin
      bad_count++;
      $display("BAD bus answer expected done seen idle");
      end_of_test();
    end
    else
      `CHK("response", r, rsp_resp)
  endtask : xfer

  task automatic rdacc(input logic two, output logic [39:0] v);
    logic [31:0] lo;
    xfer(1'b0, two ? DMAC_OFS_ACC2_LO : DMAC_OFS_ACC1_LO, 32'h0,
         DMAC_RESP_OKAY);
    lo = rsp_data;
    xfer(1'b0, two ? DMAC_OFS_ACC2_HI : DMAC_OFS_ACC1_HI, 32'h0,
         DMAC_RESP_OKAY);
    v = {rsp_data[7:0], lo};
  endtask : rdacc

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    dmac_row_t r;
    logic [39:0] v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'b0, DMAC_OFS_CONFIG, 32'h0, DMAC_RESP_OKAY);
    `CHK("config reset", 32'h00000001, rsp_data)
    xfer(1'b1, DMAC_OFS_CONFIG, 32'hffffffff, DMAC_RESP_OKAY);
    xfer(1'b0, DMAC_OFS_CONFIG, 32'h0, DMAC_RESP_OKAY);
    `CHK("config bits", {16'h0000, DMAC_CFG_WMASK}, rsp_data)
    // accumulators are read only; an unmapped place answers with an error
    xfer(1'b1, DMAC_OFS_ACC1_LO, 32'h00000001, DMAC_RESP_SLVERR);
    xfer(1'b1, 8'h30, 32'h00000001, DMAC_RESP_SLVERR);
    xfer(1'b0, 8'h24, 32'h0, DMAC_RESP_SLVERR);
    rdacc(1'b0, v);
    `CHK("acc reset", 40'h0000000000, v)
    for (int i = 0; i < 29; i++)
    begin
      r = rows[i];
      slow <= i[0];
      xfer(1'b1, DMAC_OFS_CONFIG, {16'h0000, r.cfg}, DMAC_RESP_OKAY);
      xfer(1'b1, DMAC_OFS_OPERAND, r.opnd, DMAC_RESP_OKAY);
      xfer(1'b1, DMAC_OFS_CMD, {16'h0000, r.cmd}, DMAC_RESP_OKAY);
      if (r.cmd[3:0] == 4'hd)
      begin
        xfer(1'b0, DMAC_OFS_MUL, 32'h0, DMAC_RESP_OKAY);
        `CHK("product", r.acc[31:0], rsp_data)
      end
      else
      begin
        rdacc(r.cmd[4], v);
        `CHK("a0", r.acc[15:0], v[15:0])
        `CHK("a1", r.acc[31:16], v[31:16])
        `CHK("a2", r.acc[39:32], v[39:32])
        `CHK("acc", r.acc, v)
      end
      xfer(1'b0, DMAC_OFS_STATUS, 32'h0, DMAC_RESP_OKAY);
      v = {8'h00, rsp_data};
      `CHK("guard", {r.st[4], r.st[1:0]}, {v[4], v[1:0]})
      `CHK("sat", r.st[3:2], v[3:2])
      `CHK("any sat", r.st[5], v[5])
      if (r.clr)
        xfer(1'b1, DMAC_OFS_STATUS, 32'h0000000c, DMAC_RESP_OKAY);
    end
    // a second reset in mid-run must empty the other accumulator too
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdacc(1'b1, v);
    `CHK("acc two reset", 40'h0000000000, v)
    end_of_test();
  end

endmodule : tb_top

`default_nettype wire
